// >>> hdl/lsc_pkg.sv
// Purpose: shared constants and types of the link state controller
// Assumes: one 200 MHz clock; receiver indications arrive on that clock with a frame tick
// Notes:   register offsets are byte addresses on a 32-bit AXI4-Lite bus
package lsc_pkg;

	// ----------------------------------------------------------------
	// link states and frame classes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		LSC_S0_ACQUIRE = 2'b00,
		LSC_S1_WAIT    = 2'b01,
		LSC_S2_DATA    = 2'b10
	} lsc_state_t;

	typedef enum logic [1:0]
	{
		LSC_CLS_FILL0 = 2'b00,
		LSC_CLS_FILL1 = 2'b01,
		LSC_CLS_DATA  = 2'b10,
		LSC_CLS_ERR   = 2'b11
	} lsc_cls_t;

	// ----------------------------------------------------------------
	// frame counts
	// ----------------------------------------------------------------
	localparam logic [7:0] LSC_LOCKOUT_FRAMES = 8'h80;
	localparam logic [7:0] LSC_CLEAN_FRAMES   = 8'h80;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] LSC_CTRL_OFS   = 8'h00;
	localparam logic [7:0] LSC_STATUS_OFS = 8'h04;
	localparam logic [7:0] LSC_ERRCNT_OFS = 8'h08;

	localparam int LSC_CTRL_HOLD_BIT  = 0;
	localparam int LSC_CTRL_CLEAR_BIT = 1;
	localparam logic LSC_CTRL_HOLD_RST = 1'b0;

	localparam int LSC_ST_STATE_LSB = 0;
	localparam int LSC_ST_LOW_BIT   = 2;
	localparam int LSC_ST_HIGH_BIT  = 3;
	localparam int LSC_ST_LOCK_BIT  = 4;
	localparam int LSC_ST_CLEAN_BIT = 5;
	localparam int LSC_ST_RESET_BIT = 6;

	localparam logic [1:0] LSC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] LSC_RESP_SLVERR = 2'b10;

endpackage

// >>> hdl/lsc_frame_if.sv
// Purpose: carries per-frame receiver indications and their classification
// Assumes: all signals on aclk
// Notes:   ev is a one-cycle pulse per classified frame
`timescale 1ns/1ps
interface lsc_frame_if;
	import lsc_pkg::*;

	logic     frame_tick;
	logic     err;
	logic     data_word;
	logic     ctrl_word;
	logic     fill_ack;
	logic     ev;
	lsc_cls_t cls;
	logic     pair;

	modport classifier (input frame_tick, err, data_word, ctrl_word, fill_ack, output ev, cls, pair);
	modport controller (output frame_tick, err, data_word, ctrl_word, fill_ack, input ev, cls, pair);

endinterface

// >>> hdl/lsc_frame_classifier.sv
// Purpose: classifies each received frame and flags two equal classes in a row
// Assumes: receiver indications are valid in the cycle of frame_tick
// Notes:   the very first frame after reset never forms a pair
`timescale 1ns/1ps
module lsc_frame_classifier
	import lsc_pkg::*;
(
	input  wire logic aclk,           // system clock
	input  wire logic aresetn,        // synchronous reset, active low
	lsc_frame_if.classifier fr        // frame indications in, class out
);

	lsc_cls_t cls_d;
	lsc_cls_t cls_q;
	logic     have_prev_q;
	logic     ev_q;
	logic     pair_q;

	// ----------------------------------------------------------------
	// classification
	// ----------------------------------------------------------------
	always_comb
	begin
		if (fr.err)
			cls_d = LSC_CLS_ERR;
		else if (fr.data_word || fr.ctrl_word)
			cls_d = LSC_CLS_DATA;
		else if (fr.fill_ack)
			cls_d = LSC_CLS_FILL1;
		else
			cls_d = LSC_CLS_FILL0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cls_q       <= LSC_CLS_ERR;
			have_prev_q <= 1'b0;
			ev_q        <= 1'b0;
			pair_q      <= 1'b0;
		end
		else
		begin
			ev_q <= fr.frame_tick;
			if (fr.frame_tick)
			begin
				pair_q      <= have_prev_q && (cls_d == cls_q);
				cls_q       <= cls_d;
				have_prev_q <= 1'b1;
			end
		end
	end

	assign fr.ev   = ev_q;
	assign fr.cls  = cls_q;
	assign fr.pair = pair_q;

	pair_equal_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(fr.frame_tick && have_prev_q) |=> (pair_q == (cls_q == $past(cls_q))) || $past(!fr.frame_tick))
		else $error("pair flag does not match two equal frame classes");

endmodule // lsc_frame_classifier

// >>> hdl/lsc_link_state_controller.sv
// Purpose: link startup controller: acquisition, peer wait, data mode
// Assumes: receiver indications are same-clock logic qualified by frame_tick; the two reset pins are asynchronous
// Notes:   all state advances only on frame ticks; resets and hold act every cycle
`timescale 1ns/1ps
module lsc_link_state_controller
	import lsc_pkg::*;
#(
	parameter int ADDR_W = 8                    // AXI address width
)
(
	input  wire logic              aclk,                  // 200 MHz clock
	input  wire logic              aresetn,               // synchronous reset, active low
	input  wire logic              controller_reset_a_n,  // reset pin a, active low, async
	input  wire logic              controller_reset_b_n,  // reset pin b, active low, async
	input  wire logic              frame_tick,            // one pulse per received frame
	input  wire logic              rx_frame_error,        // frame error indication
	input  wire logic              data_word_valid,       // data frame received
	input  wire logic              control_word_valid,    // control frame received
	input  wire logic              fill_word_seen,        // fill frame is acknowledge fill
	output logic                   status_low_bit,        // low status output
	output logic                   status_high_bit,       // high status output
	output logic                   tx_data_enable,        // transmitter data enable
	output logic                   tx_fill_type_select,   // transmitter fill type
	output logic                   freq_detector_disable, // receiver detector select
	output logic                   rx_active,             // receiver accepts data frames
	output logic                   ready_for_host_data,   // retimed data enable
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,          // write address
	input  wire logic              s_axi_awvalid,         // write address valid
	output logic                   s_axi_awready,         // write address ready
	input  wire logic [31:0]       s_axi_wdata,           // write data
	input  wire logic [3:0]        s_axi_wstrb,           // write byte strobes
	input  wire logic              s_axi_wvalid,          // write data valid
	output logic                   s_axi_wready,          // write data ready
	output logic [1:0]             s_axi_bresp,           // write response
	output logic                   s_axi_bvalid,          // write response valid
	input  wire logic              s_axi_bready,          // write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,          // read address
	input  wire logic              s_axi_arvalid,         // read address valid
	output logic                   s_axi_arready,         // read address ready
	output logic [31:0]            s_axi_rdata,           // read data
	output logic [1:0]             s_axi_rresp,           // read response
	output logic                   s_axi_rvalid,          // read data valid
	input  wire logic              s_axi_rready           // read data ready
);

	lsc_frame_if fr ();

	lsc_state_t  state_q;
	lsc_state_t  state_d;
	logic [1:0]  ra_sync_q;
	logic [1:0]  rb_sync_q;
	logic        rst_any;
	logic        err_pair;
	logic        advance;
	logic [7:0]  lock_cnt_q;
	logic [7:0]  clean_cnt_q;
	logic        stat_lo_q;
	logic        stat_hi_q;
	logic        ready_q;
	logic        hold_q;
	logic [15:0] err_cnt_q;
	logic        aw_got_q;
	logic        w_got_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        do_write;
	logic        clear_req;

	// ----------------------------------------------------------------
	// frame classification
	// ----------------------------------------------------------------
	assign fr.frame_tick = frame_tick;
	assign fr.err        = rx_frame_error;
	assign fr.data_word  = data_word_valid;
	assign fr.ctrl_word  = control_word_valid;
	assign fr.fill_ack   = fill_word_seen;

	lsc_frame_classifier u_classifier
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.fr      (fr)
	);

	// ----------------------------------------------------------------
	// reset pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ra_sync_q <= 2'b00;
			rb_sync_q <= 2'b00;
		end
		else
		begin
			ra_sync_q <= {ra_sync_q[0], controller_reset_a_n};
			rb_sync_q <= {rb_sync_q[0], controller_reset_b_n};
		end
	end

	// software hold acts like a third reset so a link can be parked
	assign rst_any  = !ra_sync_q[1] || !rb_sync_q[1] || hold_q;
	assign err_pair = fr.ev && fr.pair && (fr.cls == LSC_CLS_ERR);
	assign advance  = fr.ev && fr.pair && (lock_cnt_q == 8'h00);

	// ----------------------------------------------------------------
	// lockout timer and error-free counter
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || rst_any)
			lock_cnt_q <= LSC_LOCKOUT_FRAMES;
		else if (err_pair)
			lock_cnt_q <= LSC_LOCKOUT_FRAMES;
		else if (fr.ev && lock_cnt_q != 8'h00)
			lock_cnt_q <= lock_cnt_q - 8'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || rst_any)
			clean_cnt_q <= 8'h00;
		else if (fr.ev && fr.cls == LSC_CLS_ERR)
			clean_cnt_q <= 8'h00;
		else if (fr.ev && clean_cnt_q != LSC_CLEAN_FRAMES)
			clean_cnt_q <= clean_cnt_q + 8'h01;
	end

	// ----------------------------------------------------------------
	// link state machine
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		if (rst_any || err_pair)
			state_d = LSC_S0_ACQUIRE;
		else if (advance)
		begin
			case (state_q)
				LSC_S0_ACQUIRE:
					if (clean_cnt_q == LSC_CLEAN_FRAMES &&
					    (fr.cls == LSC_CLS_FILL0 || fr.cls == LSC_CLS_FILL1))
						state_d = LSC_S1_WAIT;
				LSC_S1_WAIT:
					if (fr.cls == LSC_CLS_FILL1 || fr.cls == LSC_CLS_DATA)
						state_d = LSC_S2_DATA;
					else if (fr.cls == LSC_CLS_FILL0)
						state_d = LSC_S0_ACQUIRE;
				LSC_S2_DATA:
					if (fr.cls == LSC_CLS_FILL0)
						state_d = LSC_S0_ACQUIRE;
				default:
					state_d = LSC_S0_ACQUIRE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_q <= LSC_S0_ACQUIRE;
		else
			state_q <= state_d;
	end

	// status follows the next state so the status outputs never lag the state register; ready_for_host_data lags status_low_bit by one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stat_hi_q <= 1'b0;
			stat_lo_q <= 1'b0;
			ready_q   <= 1'b0;
		end
		else
		begin
			stat_hi_q <= (state_d != LSC_S0_ACQUIRE);
			stat_lo_q <= (state_d == LSC_S2_DATA);
			ready_q   <= stat_lo_q;
		end
	end

	assign status_low_bit        = stat_lo_q;
	assign status_high_bit       = stat_hi_q;
	assign tx_data_enable        = stat_lo_q;
	assign tx_fill_type_select   = stat_hi_q;
	assign freq_detector_disable = stat_hi_q;
	assign rx_active             = stat_hi_q;
	assign ready_for_host_data   = ready_q;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign do_write  = aw_got_q && w_got_q && !bvalid_q;
	assign clear_req = do_write && (aw_addr_q == LSC_CTRL_OFS) && wstrb_q[0]
	                   && wdata_q[LSC_CTRL_CLEAR_BIT];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			aw_addr_q <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= LSC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && awready_q)
			begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid && wready_q)
			begin
				w_got_q  <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
				wready_q <= 1'b0;
			end
			if (do_write)
			begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= (aw_addr_q == LSC_CTRL_OFS) ? LSC_RESP_OKAY : LSC_RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready)
			begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hold_q <= LSC_CTRL_HOLD_RST;
		else if (do_write && aw_addr_q == LSC_CTRL_OFS && wstrb_q[0])
			hold_q <= wdata_q[LSC_CTRL_HOLD_BIT];
	end

	// a counted error in the clearing cycle survives as a count of one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			err_cnt_q <= 16'h0000;
		else if (clear_req)
			err_cnt_q <= (fr.ev && fr.cls == LSC_CLS_ERR) ? 16'h0001 : 16'h0000;
		else if (fr.ev && fr.cls == LSC_CLS_ERR && err_cnt_q != 16'hffff)
			err_cnt_q <= err_cnt_q + 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= LSC_RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= LSC_RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			case (s_axi_araddr)
				LSC_CTRL_OFS:
					rdata_q[LSC_CTRL_HOLD_BIT] <= hold_q;
				LSC_STATUS_OFS:
				begin
					rdata_q[LSC_ST_STATE_LSB +: 2] <= state_q;
					rdata_q[LSC_ST_LOW_BIT]        <= stat_lo_q;
					rdata_q[LSC_ST_HIGH_BIT]       <= stat_hi_q;
					rdata_q[LSC_ST_LOCK_BIT]       <= (lock_cnt_q != 8'h00);
					rdata_q[LSC_ST_CLEAN_BIT]      <= (clean_cnt_q == LSC_CLEAN_FRAMES);
					rdata_q[LSC_ST_RESET_BIT]      <= rst_any;
				end
				LSC_ERRCNT_OFS:
					rdata_q[15:0] <= err_cnt_q;
				default:
					rresp_q <= LSC_RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	reset_holds_s0_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_any |=> (state_q == LSC_S0_ACQUIRE) && !stat_hi_q && !stat_lo_q)
		else $error("controller left state 0 while a reset was held");

	debounce_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q != $past(state_q) && state_q != LSC_S0_ACQUIRE) |-> $past(fr.ev && fr.pair))
		else $error("state advanced without two equal frames");

	err_lockout_a: assert property (@(posedge aclk) disable iff (!aresetn)
		err_pair |=> (lock_cnt_q == LSC_LOCKOUT_FRAMES) && (state_q == LSC_S0_ACQUIRE))
		else $error("two errors did not force a 128 frame lockout");

	clean_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(stat_hi_q) |-> ($past(clean_cnt_q) == LSC_CLEAN_FRAMES) && ($past(lock_cnt_q) == 8'h00))
		else $error("left state 0 before 128 clean frames");

	s0_outputs_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == LSC_S0_ACQUIRE) |-> !tx_data_enable && !tx_fill_type_select && !freq_detector_disable)
		else $error("state 0 outputs not all low");

	lock_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(stat_hi_q) |-> $past(fr.cls == LSC_CLS_FILL0 || fr.cls == LSC_CLS_FILL1))
		else $error("high status rose without fill frames");

	ack_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(stat_lo_q) |-> $past(stat_hi_q) && $past(fr.cls != LSC_CLS_FILL0))
		else $error("low status rose outside state 1 or on square fill");

	ready_retime_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(stat_lo_q) |=> $rose(ready_for_host_data) ##1 (ready_for_host_data == $past(stat_lo_q)))
		else $error("ready indication not retimed from data enable");

	bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before acceptance");

endmodule // lsc_link_state_controller

// >>> testbench/lsc_peer_model.sv
// Purpose: far-end frame source giving receiver indications, one frame class per tick
// Assumes: bench holds cls for whole frames and raises go to send
// Notes:   indications wiggle between frames so idle values never pass for a frame
`timescale 1ns/1ps
module lsc_peer_model
	import lsc_pkg::*;
(
	input  wire logic     aclk,               // system clock
	input  wire logic     aresetn,            // synchronous reset, active low
	input  wire logic     go,                 // send frames while high
	input  wire lsc_cls_t cls,                // class of frames to send
	output logic          frame_tick,         // one pulse per frame
	output logic          rx_frame_error,     // error indication
	output logic          data_word_valid,    // data word indication
	output logic          control_word_valid, // control word indication
	output logic          fill_word_seen      // acknowledge fill indication
);
	logic [1:0] ph_q;
	logic       alt_q;

	// ----------------------------------------------------------------
	// pacing: a frame every four cycles, above the two-cycle minimum
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ph_q <= 2'h0;
		else
			ph_q <= ph_q + 2'h1;
	end

	// data frames alternate data and control words so both inputs are used
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			alt_q <= 1'b0;
		else if (frame_tick && cls == LSC_CLS_DATA)
			alt_q <= ~alt_q;
	end

	assign frame_tick         = go && ph_q == 2'h3;
	assign rx_frame_error     = frame_tick ? cls == LSC_CLS_ERR : ph_q[0];
	assign data_word_valid    = frame_tick ? cls == LSC_CLS_DATA && !alt_q : ~ph_q[0];
	assign control_word_valid = frame_tick ? cls == LSC_CLS_DATA && alt_q : ph_q[0];
	assign fill_word_seen     = frame_tick ? cls == LSC_CLS_FILL1 : ph_q[1];
endmodule // lsc_peer_model

// >>> testbench/test_serial_link_startup_handshake_fsm.sv
// Purpose: self-checking bench of the link state controller
// Assumes: frames come from the peer model; registers over AXI4-Lite
// Notes:   row table walks startup, errors and fall-back; resets and registers after it
`timescale 1ns/1ps
module test_serial_link_startup_handshake_fsm;
	import lsc_pkg::*;
	typedef struct {lsc_cls_t c; int n; logic h; logic l;} lsc_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, rst_a_n = 1'b1, rst_b_n = 1'b1, go = 1'b0;
	lsc_cls_t cls = LSC_CLS_FILL0;
	logic tick, ferr, dwv, cwv, fws, shi, slo, tde, fts, fdd, act, rdy;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [3:0]  wstrb = 4'hf;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	int n_mismatch = 0, num_checks = 0;
	lsc_row_t rows [13] = '{'{LSC_CLS_FILL0, 128, 0, 0}, '{LSC_CLS_FILL0, 1, 1, 0},
		'{LSC_CLS_FILL1, 1, 1, 0}, '{LSC_CLS_FILL1, 1, 1, 1}, '{LSC_CLS_ERR, 1, 1, 1},
		'{LSC_CLS_DATA, 1, 1, 1}, '{LSC_CLS_ERR, 2, 0, 0}, '{LSC_CLS_FILL0, 128, 0, 0},
		'{LSC_CLS_FILL0, 1, 1, 0}, '{LSC_CLS_DATA, 2, 1, 1}, '{LSC_CLS_FILL0, 1, 1, 1},
		'{LSC_CLS_FILL0, 1, 0, 0}, '{LSC_CLS_FILL0, 1, 1, 0}};

	always #2.5 aclk = ~aclk;

	lsc_peer_model lsc_peer_model_i (.aclk(aclk), .aresetn(aresetn), .go(go), .cls(cls), .frame_tick(tick),
		.rx_frame_error(ferr), .data_word_valid(dwv), .control_word_valid(cwv), .fill_word_seen(fws));

	lsc_link_state_controller lsc_link_state_controller_i (.aclk(aclk), .aresetn(aresetn),
		.controller_reset_a_n(rst_a_n), .controller_reset_b_n(rst_b_n), .frame_tick(tick),
		.rx_frame_error(ferr), .data_word_valid(dwv), .control_word_valid(cwv), .fill_word_seen(fws),
		.status_low_bit(slo), .status_high_bit(shi), .tx_data_enable(tde), .tx_fill_type_select(fts),
		.freq_detector_disable(fdd), .rx_active(act), .ready_for_host_data(rdy),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// valids held until their own ready is sampled; bready held until bvalid
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic frames(input lsc_cls_t c, input int n);
		int k;
		k = 0;
		cls <= c;
		go <= 1'b1;
		while (k < n)
		begin
			@(posedge aclk);
			if (tick)
				k++;
		end
		go <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask

	function automatic logic [31:0] outs();
		return 32'({shi, fts, fdd, act, slo, tde, rdy});
	endfunction

	initial
	begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		summarize();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("outs after reset", outs(), 32'h0);
		foreach (rows[i])
		begin
			frames(rows[i].c, rows[i].n);
			chk("outs", outs(), 32'({{4{rows[i].h}}, {3{rows[i].l}}}));
		end
		$display("test table done");
		axi_rd(LSC_ERRCNT_OFS, rd, rsp);
		chk("errcnt", rd, 32'h3);
		axi_wr(LSC_CTRL_OFS, 32'h2, rsp);
		axi_rd(LSC_ERRCNT_OFS, rd, rsp);
		chk("errcnt cleared", rd, 32'h0);
		axi_rd(LSC_STATUS_OFS, rd, rsp);
		chk("status", rd & 32'hf, 32'h9);
		axi_rd(8'h0c, rd, rsp);
		chk("unmapped resp", 32'(rsp), 32'(LSC_RESP_SLVERR));
		chk("unmapped data", rd, 32'h0);
		axi_wr(LSC_STATUS_OFS, 32'hff, rsp);
		chk("ro write resp", 32'(rsp), 32'(LSC_RESP_SLVERR));
		// byte 0 strobe low: the hold bit must not change
		wstrb <= 4'he;
		axi_wr(LSC_CTRL_OFS, 32'h1, rsp);
		wstrb <= 4'hf;
		axi_rd(LSC_CTRL_OFS, rd, rsp);
		chk("ctrl strobe", rd, 32'h0);
		axi_wr(LSC_CTRL_OFS, 32'h1, rsp);
		axi_rd(LSC_CTRL_OFS, rd, rsp);
		chk("ctrl hold", rd, 32'h1);
		chk("outs held", outs(), 32'h0);
		axi_wr(LSC_CTRL_OFS, 32'h0, rsp);
		chk("ctrl resp", 32'(rsp), 32'(LSC_RESP_OKAY));
		frames(LSC_CLS_FILL0, 128);
		chk("outs lockout", outs(), 32'h0);
		frames(LSC_CLS_FILL0, 1);
		chk("outs locked", outs(), 32'h78);
		$display("test registers done");
		rst_b_n <= 1'b0;
		frames(LSC_CLS_FILL0, 4);
		chk("outs reset b", outs(), 32'h0);
		rst_b_n <= 1'b1;
		repeat (5) @(posedge aclk);
		frames(LSC_CLS_FILL0, 128);
		chk("outs after b", outs(), 32'h0);
		frames(LSC_CLS_FILL0, 1);
		chk("outs relock", outs(), 32'h78);
		rst_a_n <= 1'b0;
		repeat (5) @(posedge aclk);
		chk("outs reset a", outs(), 32'h0);
		rst_a_n <= 1'b1;
		$display("test reset pins done");
		summarize();
	end
endmodule // test_serial_link_startup_handshake_fsm
